/* File: lsq_sequencer.sv */
// Start-up sequencer: supply lockout, start-up pin switching, PF and
// thermal configuration, initial thermal check, soft-start release.
// Assumes comparators and a resistance converter in the analog stage.
//
// Operation
// - Enable: open follow, wait, close source
// - Lockout: shut down, re-close follow, restart
// - Configure once per enable, before soft-start
// - Gate drive held off during PF
// - Source current on PF pin, measure
// - PF resistance decodes into four levels
// - Then source on feedback pin, measure
// - Divider resistance decodes into three levels
// - External variant: steps 5, 7.5, 10%
// - Internal variant: starts 100, 110, 120C
// - Thermal check gates soft-start release
// - Run: feedback pin becomes voltage sense
// - Enable above start threshold, off below lockout
// - Follow switch closes at about 1V
`timescale 1ns/1ns
`default_nettype none
module lsq_sequencer
   import lsq_pkg::*;
#(
   parameter int SETTLE_CYC = SW_SETTLE_CYC,
   parameter int MEAS_CYC   = MEAS_SETTLE_CYC
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Supply comparators (asynchronous)
   input  wire logic             vcc_above_1v,
   input  wire logic             vcc_above_start,
   input  wire logic             vcc_above_lockout,
   // Thermal inputs (asynchronous)
   input  wire logic             ext_variant,
   input  wire logic             tj_below_130,
   input  wire logic             multi_above_084,
   // Resistance measurement from converter
   input  wire logic [RES_W-1:0] meas_ohms,
   // Pin controls and results
   output lsq_pins_t             pins,
   output lsq_cfg_t              cfg,
   output logic                  enable,
   output logic                  softstart_go,
   output logic                  fb_voltage_sense
);
   // Three-stage synchronisers; change counts when stages 2 and 3 agree
   // Costs about four cycles of latency, far below the analog time scales
   logic [5:0] sy1_q, sy2_q, sy3_q, flt_q;
   wire  [5:0] raw = {multi_above_084, tj_below_130, ext_variant,
                      vcc_above_lockout, vcc_above_start, vcc_above_1v};
   wire  [5:0] agree = ~(sy2_q ^ sy3_q);
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_sync
         always_ff @(posedge clk) begin
            sy1_q[g] <= raw[g];
            sy2_q[g] <= sy1_q[g];
            sy3_q[g] <= sy2_q[g];
            if (sys_rst) begin
               flt_q[g] <= 1'b0;
            end else if (agree[g]) begin
               flt_q[g] <= sy3_q[g];
            end
         end
      end
   endgenerate
   wire v1v   = flt_q[0];
   wire vst   = flt_q[1];
   wire vlock = flt_q[2];
   wire extv  = flt_q[3];
   wire tjok  = flt_q[4];
   wire mlok  = flt_q[5];

   lsq_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   lsq_cfg_t cfg_q, cfg_d;

   wire [RES_W:0] pf_b12 = ({1'b0, PF1_MAX} + {1'b0, PF2_MIN}) >> 1;
   wire [RES_W:0] pf_b23 = ({1'b0, PF2_MAX} + {1'b0, PF3_MIN}) >> 1;
   wire [RES_W:0] pf_b34 = ({1'b0, PF3_MAX} + {1'b0, PF4_MIN}) >> 1;
   wire [RES_W:0] m17    = {1'b0, meas_ohms};
   wire [1:0] pf_lvl = (m17 <= pf_b12) ? 2'h0 :
                       (m17 <= pf_b23) ? 2'h1 :
                       (m17 <= pf_b34) ? 2'h2 : 2'h3;
   wire [RES_W:0] th_b12 = ({1'b0, TH1_MAX} + {1'b0, TH2_MIN}) >> 1;
   wire [RES_W:0] th_b23 = ({1'b0, TH2_MAX} + {1'b0, TH3_MIN}) >> 1;
   wire [1:0] th_lvl = (m17 <= th_b12) ? 2'h0 :
                       (m17 <= th_b23) ? 2'h1 : 2'h2;
   wire [7:0] step_sel = (th_lvl == 2'h0) ? STEP_L1 :
                         (th_lvl == 2'h1) ? STEP_L2 : STEP_L3;
   wire [7:0] temp_sel = (th_lvl == 2'h0) ? TSTART_L1 :
                         (th_lvl == 2'h1) ? TSTART_L2 : TSTART_L3;
   wire therm_ok = extv ? mlok : tjok;
   // Counter parks at zero; each window loads its own length
   wire cnt_done = (cnt_q == '0);

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_done ? cnt_q : cnt_q - 1'b1;
      cfg_d   = cfg_q;
      unique case (state_q)
         ST_OFF: begin
            if (v1v) begin
               state_d = ST_FOLLOW;
            end
         end
         ST_FOLLOW: begin
            // Below 1V the follow switch opens again
            // Start threshold reached, lockout comparator too
            if (!v1v) begin
               state_d = ST_OFF;
            end else if (vst && vlock) begin
               state_d = ST_GAP;
               cnt_d   = CNT_W'(SETTLE_CYC);
            end
         end
         ST_GAP: begin
            if (cnt_done) begin
               state_d = ST_PF;
               cnt_d   = CNT_W'(MEAS_CYC);
            end
         end
         ST_PF: begin
            // Sample PF resistance
            // Reading taken on the last cycle of the window, once settled
            if (cnt_done) begin
               cfg_d.pf_level = pf_lvl;
               state_d = ST_THERM;
               cnt_d   = CNT_W'(MEAS_CYC);
            end
         end
         ST_THERM: begin
            if (cnt_done) begin
               cfg_d.th_level    = th_lvl;
               cfg_d.derate_step = step_sel;
               cfg_d.derate_temp = temp_sel;
               state_d = ST_CHECK;
            end
         end
         ST_CHECK: begin
            // Release when cool
            // Waits as long as it takes while hot; no timeout here
            if (therm_ok) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            state_d = ST_RUN;
         end
         default: state_d = ST_OFF;
      endcase
      // Lockout overrides all
      // Old config is kept but rewritten in full on the next start-up
      if (state_q != ST_OFF && state_q != ST_FOLLOW && !vlock) begin
         state_d = v1v ? ST_FOLLOW : ST_OFF;
      end
   end

   // State registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_OFF;
         cnt_q   <= '0;
         cfg_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         cfg_q   <= cfg_d;
      end
   end

   // Pin controls registered from next state, glitch free
   lsq_pins_t pins_q;
   logic en_q, ss_q, fbv_q;
   wire in_cfg = (state_d == ST_PF) || (state_d == ST_THERM);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pins_q <= '0;
         en_q   <= 1'b0;
         ss_q   <= 1'b0;
         fbv_q  <= 1'b0;
      end else begin
         pins_q.supply_follow_switch  <= (state_d == ST_FOLLOW);
         // Source stays on through run so the start-up device stays cut off
         pins_q.current_source_switch <= (state_d != ST_OFF) && (state_d != ST_FOLLOW)
                                         && (state_d != ST_GAP);
         pins_q.pf_src_en <= (state_d == ST_PF);
         pins_q.fb_src_en <= (state_d == ST_THERM);
         pins_q.gate_hold_off <= (state_d != ST_RUN) || in_cfg;
         en_q  <= (state_d != ST_OFF) && (state_d != ST_FOLLOW);
         ss_q  <= (state_d == ST_RUN);
         fbv_q <= (state_d == ST_RUN);
      end
   end
   assign pins             = pins_q;
   assign cfg              = cfg_q;
   assign enable           = en_q;
   assign softstart_go     = ss_q;
   assign fb_voltage_sense = fbv_q;
endmodule
`default_nettype wire

/* File: lsq_pkg.sv */
// Package for the LED start-up configuration sequencer.
// Assumes a 250 MHz clock and resistance values from an outside converter in ohms.
package lsq_pkg;
   // Clock period in ns
   localparam int CLK_NS = 4;
   // Settle time between switch changes, ns
   localparam int SW_SETTLE_NS = 2000;
   localparam int SW_SETTLE_CYC = (SW_SETTLE_NS + CLK_NS - 1) / CLK_NS;
   // Measurement settle time per pin, ns
   localparam int MEAS_SETTLE_NS = 10000;
   localparam int MEAS_SETTLE_CYC = (MEAS_SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 12;

   // Resistance width, ohms
   localparam int RES_W = 16;
   // PF ranges, ohms; gap boundaries at midpoints between ranges
   localparam logic [15:0] PF1_MAX = 16'h0370; // 880
   localparam logic [15:0] PF2_MIN = 16'h0550; // 1360
   localparam logic [15:0] PF2_MAX = 16'h0BB8; // 3000
   localparam logic [15:0] PF3_MIN = 16'h0F1E; // 3870
   localparam logic [15:0] PF3_MAX = 16'h15E0; // 5600
   localparam logic [15:0] PF4_MIN = 16'h1B26; // 6950
   // Thermal ranges, ohms
   localparam logic [15:0] TH1_MIN = 16'h0708; // 1800
   localparam logic [15:0] TH1_MAX = 16'h08CA; // 2250
   localparam logic [15:0] TH2_MIN = 16'h0B9A; // 2970
   localparam logic [15:0] TH2_MAX = 16'h0EC4; // 3780
   localparam logic [15:0] TH3_MIN = 16'h12AC; // 4780

   // Derating step in tenths of a percent
   localparam logic [7:0] STEP_L1 = 8'h32; // 5.0%
   localparam logic [7:0] STEP_L2 = 8'h4B; // 7.5%
   localparam logic [7:0] STEP_L3 = 8'h64; // 10%
   // Derating start temperature, deg C
   localparam logic [7:0] TSTART_L1 = 8'h64; // 100
   localparam logic [7:0] TSTART_L2 = 8'h6E; // 110
   localparam logic [7:0] TSTART_L3 = 8'h78; // 120

   // Sequencer states
   typedef enum logic [2:0] {
      ST_OFF   = 3'b000,
      ST_FOLLOW= 3'b001,
      ST_GAP   = 3'b010,
      ST_PF    = 3'b011,
      ST_THERM = 3'b100,
      ST_CHECK = 3'b101,
      ST_RUN   = 3'b110
   } lsq_state_t;

   // Configuration result carried to the power stage
   typedef struct packed {
      logic [1:0] pf_level;    // 0..3 means level 1..4
      logic [1:0] th_level;    // 0..2 means level 1..3
      logic [7:0] derate_step; // tenths of a percent
      logic [7:0] derate_temp; // deg C
   } lsq_cfg_t;

   // Switch and current-source controls toward the pins
   typedef struct packed {
      logic supply_follow_switch;
      logic current_source_switch;
      logic pf_src_en;
      logic fb_src_en;
      logic gate_hold_off;
   } lsq_pins_t;
endpackage

/* File: lsq_seq_asserts.sv */
// Port checker for the start-up sequencer.
// Assumes it is bound to lsq_sequencer and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module lsq_seq_asserts
   import lsq_pkg::*;
(
   // Clock, reset and inputs
   input wire logic             clk,
   input wire logic             sys_rst,
   input wire logic             vcc_above_1v,
   input wire logic             vcc_above_start,
   input wire logic             vcc_above_lockout,
   input wire logic             ext_variant,
   input wire logic             tj_below_130,
   input wire logic             multi_above_084,
   input wire logic [RES_W-1:0] meas_ohms,
   // Outputs
   input wire lsq_pins_t        pins,
   input wire lsq_cfg_t         cfg,
   input wire logic             enable,
   input wire logic             softstart_go,
   input wire logic             fb_voltage_sense
);
   // One clock domain, so defaults hold for all
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_gate_pf_off: assert property (pins.pf_src_en |-> pins.gate_hold_off)
      else $error("Gate active in PF measure");
   chk_one_source: assert property (pins.fb_src_en |-> !pins.pf_src_en && pins.gate_hold_off)
      else $error("Both pins sourced");
   chk_enable_follow: assert property (enable |-> !pins.supply_follow_switch)
      else $error("Follow closed while enabled");
   // Source closes only after a settle gap behind enable
   chk_source_wait: assert property ($rose(pins.current_source_switch) |-> $past(enable, 3))
      else $error("Source closed too early");
   chk_lockout_off: assert property (!vcc_above_lockout [*8] |-> !enable)
      else $error("Enable held in lockout");
   chk_follow_low: assert property (!vcc_above_1v [*8] |-> !pins.supply_follow_switch)
      else $error("Follow closed below 1V");
   chk_no_run_off: assert property (!enable |-> !softstart_go)
      else $error("Soft-start without enable");
   chk_run_sense: assert property ($rose(softstart_go) |-> fb_voltage_sense && !pins.gate_hold_off)
      else $error("Run entered without sense");
   chk_cfg_held: assert property (softstart_go && $past(softstart_go) |-> $stable(cfg))
      else $error("Config changed in run");
   chk_derate_map: assert property (softstart_go |-> cfg.derate_step ==
      (cfg.th_level == 2'h0 ? STEP_L1 : cfg.th_level == 2'h1 ? STEP_L2 : STEP_L3))
      else $error("Derate step mismatch");
   cover property ($rose(softstart_go));
   cover property ($fell(enable));
   cover property ($rose(pins.fb_src_en));
endmodule
bind lsq_sequencer lsq_seq_asserts lsq_seq_asserts_inst (.clk, .sys_rst, .vcc_above_1v,
   .vcc_above_start, .vcc_above_lockout, .ext_variant, .tj_below_130, .multi_above_084,
   .meas_ohms, .pins, .cfg, .enable, .softstart_go, .fb_voltage_sense);
`default_nettype wire

/* File: lsq_stage_model.sv */
// Analog stage model: converter answers for the sourced pin.
// Assumes the bench sets both resistances before each start-up.
`timescale 1ns/1ns
`default_nettype none
module lsq_stage_model
   import lsq_pkg::*;
(
   // Clock and pin controls
   input  wire logic             clk,
   input  wire lsq_pins_t        pins,
   // Resistance on each pin, ohms
   input  wire logic [RES_W-1:0] r_pf,
   input  wire logic [RES_W-1:0] r_fb,
   // Converter result
   output logic      [RES_W-1:0] meas_ohms
);
   // Idle converter toggles, so a stale reading cannot pass
   logic [RES_W-1:0] idle_q = 16'h5A5A;
   always @(posedge clk) idle_q <= ~idle_q;
   assign meas_ohms = pins.pf_src_en ? r_pf : (pins.fb_src_en ? r_fb : idle_q);
endmodule
`default_nettype wire

/* File: test_lsq_sequencer.sv */
// Testbench for the start-up sequencer with the stage model.
// Assumes lsq_pkg, the checker and the stage model compile first.
`timescale 1ns/1ns
`default_nettype none
module test_lsq_sequencer;
   import lsq_pkg::*;
   logic        clk = 1'b0, sys_rst = 1'b1, v1 = 1'b0, vst = 1'b0, vlo = 1'b0;
   logic        ext = 1'b0, tj_ok = 1'b1, mu_ok = 1'b1, en, go, fbv;
   logic [15:0] r_pf = 16'h0000, r_fb = 16'h0000, ohms;
   logic [31:0] rng = 32'h00003D1B; // Seed 15643
   lsq_pins_t   pins;
   lsq_cfg_t    cfg;
   lsq_cfg_t    exp_q[$];
   int          failures = 0, cmp_count = 0, cyc = 0;
   // Gap edges sit at the midpoints between ranges
   logic [15:0] pf_tab[8] = '{16'h0000, 16'h0460, 16'h0461, 16'h0D6B, 16'h0D6C, 16'h1883,
                              16'h1884, 16'hFFFF};
   logic [15:0] th_tab[6] = '{16'h0000, 16'h0A32, 16'h0A33, 16'h10B8, 16'h10B9, 16'hFFFF};
   lsq_sequencer #(.SETTLE_CYC(4), .MEAS_CYC(8)) lsq_sequencer_inst (.clk, .sys_rst,
      .vcc_above_1v(v1), .vcc_above_start(vst), .vcc_above_lockout(vlo), .ext_variant(ext),
      .tj_below_130(tj_ok), .multi_above_084(mu_ok), .meas_ohms(ohms), .pins, .cfg,
      .enable(en), .softstart_go(go), .fb_voltage_sense(fbv));
   lsq_stage_model lsq_stage_model_inst (.clk, .pins, .r_pf, .r_fb, .meas_ohms(ohms));
   initial forever #2 clk = ~clk;
   // Cycle ceiling well above the twelve start-ups
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         test_done();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic lsq_cfg_t expect_cfg(input logic [15:0] rp, input logic [15:0] rf);
      lsq_cfg_t c;
      c.pf_level = (rp <= 16'h0460) ? 2'h0 : (rp <= 16'h0D6B) ? 2'h1 :
                   (rp <= 16'h1883) ? 2'h2 : 2'h3;
      c.th_level = (rf <= 16'h0A32) ? 2'h0 : (rf <= 16'h10B8) ? 2'h1 : 2'h2;
      c.derate_step = (c.th_level == 2'h0) ? 8'h32 : (c.th_level == 2'h1) ? 8'h4B : 8'h64;
      c.derate_temp = (c.th_level == 2'h0) ? 8'h64 : (c.th_level == 2'h1) ? 8'h6E : 8'h78;
      return c;
   endfunction
   task automatic check(input logic [19:0] seen, input logic [19:0] want);
      cmp_count++;
      if (seen !== want) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic supply(input logic [2:0] s, input int n);
      @(negedge clk);
      {v1, vst, vlo} = s;
      repeat (n) @(negedge clk);
   endtask
   // Monitor: each soft-start release takes the oldest note
   initial forever begin
      @(posedge go);
      #1;
      if (exp_q.size() > 0) check(cfg, exp_q.pop_front());
      else check(1'b1, 1'b0);
   end
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk) sys_rst = 1'b0;
      // Start threshold without lockout comparator is refused
      supply(3'b110, 12);
      check({pins.supply_follow_switch, en}, 2'b10);
      for (int i = 0; i < 12; i++) begin
         rng = xs(rng);
         r_pf = (i < 8) ? pf_tab[i] : rng[15:0];
         r_fb = (i < 6) ? th_tab[i] : rng[31:16];
         ext = i[0];
         tj_ok = (i != 2);
         mu_ok = (i != 3);
         exp_q.push_back(expect_cfg(r_pf, r_fb));
         supply(3'b111, 0);
         if (i == 4) begin
            for (int k = 0; k < 50 && en !== 1'b1; k++) @(negedge clk);
            supply(3'b000, 12);
            check({en, pins.current_source_switch}, 2'h0);
            supply(3'b111, 0);
         end
         if (i == 2 || i == 3) begin
            repeat (100) @(negedge clk);
            check(go, 1'b0);
            tj_ok = 1'b1;
            mu_ok = 1'b1;
         end
         for (int k = 0; k < 200 && go !== 1'b1; k++) @(negedge clk);
         check({fbv, pins.gate_hold_off, pins.current_source_switch}, 3'h5);
         supply(3'b000, 12);
         check({go, pins.supply_follow_switch}, 2'b00);
         $display("Test %0d done", i);
      end
      test_done();
   end
endmodule
`default_nettype wire
